/* File: include/xmm_defs.vh */
`ifndef XMM_DEFS_VH
`define XMM_DEFS_VH
// ======================================
// register indices (byte address = index * 4)
`define XMM_IDX_CNF1      8'hF7
`define XMM_IDX_CNF2      8'hF8
`define XMM_IDX_BASE_HIGH 8'hF9
`define XMM_IDX_BASE_LOW  8'hFA
`define XMM_IDX_SIZE      8'hFB
`define XMM_IDX_SBLK_CTL  8'hF0
`define XMM_IDX_STATUS    8'hF1
// ======================================
// reset values
`define XMM_RST_CNF1      8'h00
`define XMM_RST_CNF2      8'h00
`define XMM_RST_BASE      8'h00
`define XMM_RST_SIZE      4'h0
// ======================================
// memory_map_config_one fields
`define XMM_C1_LPC_EN     0
`define XMM_C1_EXT_EN     1
`define XMM_C1_USER_EN    2
`define XMM_C1_FWH_EN     3
`define XMM_C1_ID_LSB     4
`define XMM_C1_ID_MSB     7
// ======================================
// memory_map_config_two fields
`define XMM_C2_BSIZE_LSB  0
`define XMM_C2_BSIZE_MSB  2
`define XMM_C2_DUAL_BOOT  3
`define XMM_C2_DUAL_USER  4
`define XMM_C2_LOCK       7
`define XMM_C2_WMASK      8'h9F
// ======================================
// serial_block_control fields
`define XMM_SB_UNLOCK     0
`define XMM_SB_LOCK_SEL   1
// ======================================
// zone size exponents
`define XMM_USER_LOG2_MIN 6'd16
`define XMM_USER_SIZE_MAX 4'h8
`define XMM_BOOT_LOG2_MIN 6'd18
`define XMM_BOOT_SIZE_MAX 3'h5
`endif

/* File: hw/xmm_map_config.v */
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "xmm_defs.vh"

// Overview of operation
// RULE1: lock set blocks writes to both configs, base bytes, size, and lock itself.
// RULE2: lock cleared by hardware reset or standby reset, chosen by lock-well select.
// RULE3: writing map_unlock to one clears the lock.
// RULE4: dual user select with user memory enabled decodes zones 0 and 1.
// RULE5: user zone 1 equals zone 0 size, sitting directly above zone 0.
// RULE6: dual boot select places boot zone 1 directly below boot zone 0.
// RULE7: firmware-hub cycles: zone 0 at top addresses, zone 1 just below.
// RULE8: both boot zones match the same firmware-hub select id.
// RULE9: dual boot select acts when either boot space enabled; else zone 0 only.
// RULE10: boot size field 000 is 256 Kbytes, doubling up to 101 at 8 Mbytes.
// RULE11: base high byte compares against address bits 31 to 24.
// RULE12: base low byte compares against address bits 23 to 16.
// RULE13: base address bits 15 down to 0 are zero.
// RULE14: software aligns the base address to the zone size.
// RULE15: hardware reset loads 00h into config two and both base bytes; the lock bit of config two survives it when lock-well select is set.
// RULE16: user memory enable gates claiming cycles in the user zone.
// RULE17: user zone size is two to the size field plus sixteen bytes.
// RULE18: user hit when address bits above zone size equal the base bits.
module xmm_map_config #(
   parameter ADR_W = 10
) (
   input  wire             clock,
   input  wire             reset,
   input  wire             clock_en,
   input  wire             standby_reset,
   input  wire             strap_boot_en,
   input  wire             wb_cyc_i,
   input  wire             wb_stb_i,
   input  wire             wb_we_i,
   input  wire [ADR_W-1:0] wb_adr_i,
   input  wire [3:0]       wb_sel_i,
   input  wire [31:0]      wb_dat_i,
   output reg  [31:0]      wb_dat_o,
   output reg              wb_ack_o,
   input  wire             mem_valid,
   input  wire             mem_fwh_cycle,
   input  wire [3:0]       mem_fwh_id,
   input  wire [31:0]      mem_addr,
   output reg              user_zone0_hit_r,
   output reg              user_zone1_hit_r,
   output reg              boot_zone0_hit_r,
   output reg              boot_zone1_hit_r,
   output wire             map_lock
);

   // ======================================
   // register state
   reg  [7:0] cnf1_r;
   reg  [6:0] cnf2_lo_r;
   reg        lock_r;
   reg  [7:0] base_high_r;
   reg  [7:0] base_low_r;
   reg  [3:0] size_r;
   reg        lock_sel_r;
   reg  [3:0] hit_seen_r;
   wire [7:0] cnf2_r;

   assign cnf2_r = {lock_r, cnf2_lo_r};

   // ======================================
   // bus decode
   wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr_lane  = req & wb_we_i & wb_sel_i[0];
   wire [7:0] idx      = wb_adr_i[9:2];
   wire [7:0] wdat     = wb_dat_i[7:0];
   wire       lock     = cnf2_r[`XMM_C2_LOCK];
   wire       wr_open  = wr_lane & ~lock;
   wire       wr_cnf1  = wr_open & (idx == `XMM_IDX_CNF1);
   wire       wr_cnf2  = wr_open & (idx == `XMM_IDX_CNF2);
   wire       wr_bah   = wr_open & (idx == `XMM_IDX_BASE_HIGH);
   wire       wr_bal   = wr_open & (idx == `XMM_IDX_BASE_LOW);
   wire       wr_size  = wr_open & (idx == `XMM_IDX_SIZE);
   wire       wr_sblk  = wr_lane & (idx == `XMM_IDX_SBLK_CTL);
   wire       unlock   = wr_sblk & wdat[`XMM_SB_UNLOCK];

   assign map_lock = lock;

   // ======================================
   // next values of the configuration registers
   reg  [7:0] cnf1_nxt;
   reg  [6:0] cnf2_lo_nxt;
   reg        lock_nxt;
   reg  [7:0] base_high_nxt;
   reg  [7:0] base_low_nxt;
   reg  [3:0] size_nxt;
   reg        lock_sel_nxt;
   wire [7:0] wdat_c2  = wdat & `XMM_C2_WMASK;
   wire [7:0] rst_c1   = `XMM_RST_CNF1 | {4'h0, strap_boot_en, 2'b00, strap_boot_en};
   wire [7:0] rst_c2   = `XMM_RST_CNF2;
   wire       lock_clr = standby_reset | (reset & ~lock_sel_r);

   always @* begin
      cnf1_nxt      = cnf1_r;
      cnf2_lo_nxt   = cnf2_lo_r;
      lock_nxt      = lock_r;
      base_high_nxt = base_high_r;
      base_low_nxt  = base_low_r;
      size_nxt      = size_r;
      lock_sel_nxt  = lock_sel_r;
      if (wr_cnf1) begin                  // [RULE1]
         cnf1_nxt = wdat;
      end
      if (wr_cnf2) begin                  // [RULE1]
         cnf2_lo_nxt = wdat_c2[6:0];
         lock_nxt    = wdat[`XMM_C2_LOCK];
      end
      if (wr_bah) begin                   // [RULE1]
         base_high_nxt = wdat;
      end
      if (wr_bal) begin                   // [RULE1]
         base_low_nxt = wdat;
      end
      if (wr_size) begin                  // [RULE1]
         size_nxt = wdat[3:0];
      end
      if (wr_sblk) begin
         lock_sel_nxt = wdat[`XMM_SB_LOCK_SEL];
      end
      // unlock wins over a lock write in the same cycle
      if (unlock) begin                   // [RULE3]
         lock_nxt = 1'b0;
      end
   end

   // ======================================
   // configuration registers
   // lock-well select lives in the standby well
   always @(posedge clock) begin
      if (standby_reset) begin
         lock_sel_r <= 1'b0;
      end else if (clock_en) begin
         lock_sel_r <= lock_sel_nxt;
      end
   end

   always @(posedge clock) begin
      if (reset || standby_reset) begin
         // straps taken while reset is held
         cnf1_r      <= rst_c1;
         cnf2_lo_r   <= rst_c2[6:0];        // [RULE15]
         base_high_r <= `XMM_RST_BASE;      // [RULE15]
         base_low_r  <= `XMM_RST_BASE;      // [RULE15]
         size_r      <= `XMM_RST_SIZE;
      end else if (clock_en) begin
         cnf1_r      <= cnf1_nxt;
         cnf2_lo_r   <= cnf2_lo_nxt;
         base_high_r <= base_high_nxt;
         base_low_r  <= base_low_nxt;
         size_r      <= size_nxt;
      end
   end

   // lock survives a hardware reset when the standby well is selected
   always @(posedge clock) begin
      if (lock_clr) begin                 // [RULE2]
         lock_r <= 1'b0;
      end else if (reset) begin
         lock_r <= lock_r;
      end else if (clock_en) begin
         lock_r <= lock_nxt;
      end
   end

   // ======================================
   // read mux
   reg [7:0] rdat;
   always @* begin
      rdat = 8'h00;
      // unmapped indices read zero
      case (idx)
         `XMM_IDX_CNF1: begin
            rdat = cnf1_r;
         end
         `XMM_IDX_CNF2: begin
            rdat = cnf2_r;
         end
         `XMM_IDX_BASE_HIGH: begin
            rdat = base_high_r;
         end
         `XMM_IDX_BASE_LOW: begin
            rdat = base_low_r;
         end
         `XMM_IDX_SIZE: begin
            rdat = {4'h0, size_r};
         end
         `XMM_IDX_SBLK_CTL: begin
            rdat = {6'h00, lock_sel_r, 1'b0};
         end
         `XMM_IDX_STATUS: begin
            rdat = {3'h0, lock, hit_seen_r};
         end
         default: begin
            rdat = 8'h00;
         end
      endcase
   end

   // ======================================
   // bus answer
   reg        ack_nxt;
   reg [31:0] dat_nxt;

   always @* begin
      ack_nxt = req;
      dat_nxt = wb_dat_o;
      if (req && !wb_we_i) begin
         dat_nxt = {24'h00_0000, rdat};
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (clock_en) begin
         wb_ack_o <= ack_nxt;
         wb_dat_o <= dat_nxt;
      end
   end

   // ======================================
   // user zone decode
   reg  [3:0] usize;
   reg  [2:0] bsize;

   always @* begin
      // reserved codes above 16M act as 16M
      if (size_r > `XMM_USER_SIZE_MAX) begin
         usize = `XMM_USER_SIZE_MAX;
      end else begin
         usize = size_r;
      end
   end

   always @* begin
      // codes 110 and 111 act as 8M
      if (cnf2_r[`XMM_C2_BSIZE_MSB:`XMM_C2_BSIZE_LSB] > `XMM_BOOT_SIZE_MAX) begin
         bsize = `XMM_BOOT_SIZE_MAX;
      end else begin
         bsize = cnf2_r[`XMM_C2_BSIZE_MSB:`XMM_C2_BSIZE_LSB];
      end
   end

   // ======================================
   // zone base and masks
   wire [5:0] ulog2  = `XMM_USER_LOG2_MIN + {2'b00, usize};   // [RULE17]
   wire [31:0] ubase = {base_high_r, base_low_r, 16'h0000};   // [RULE11] [RULE12] [RULE13]
   wire [31:0] usize_b;
   wire [31:0] umask;
   wire [31:0] ubase1;
   wire [5:0]  blog2 = `XMM_BOOT_LOG2_MIN + {3'b000, bsize};  // [RULE10]
   wire [31:0] bmask;
   wire [31:0] bmask2;

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_mask
         // one marks an address bit that lies inside the zone
         assign umask[gi]   = (gi < ulog2);
         assign usize_b[gi] = (gi == ulog2);
         assign bmask[gi]   = (gi < blog2);
         assign bmask2[gi]  = (gi <= blog2);
      end
   endgenerate

   // carry out of bit 31 is dropped on purpose
   wire [32:0] ubase1_sum = {1'b0, ubase} + {1'b0, usize_b};
   assign ubase1 = ubase1_sum[31:0];                           // [RULE5]

   wire user_en   = cnf1_r[`XMM_C1_USER_EN];
   wire dual_user = cnf2_r[`XMM_C2_DUAL_USER];
   wire u0_match  = ((mem_addr ^ ubase) & ~umask) == 32'h0000_0000;  // [RULE18]
   wire u1_match  = ((mem_addr ^ ubase1) & ~umask) == 32'h0000_0000; // [RULE5]
   reg  u0_hit;
   reg  u1_hit;
   always @* begin
      u0_hit = 1'b0;
      u1_hit = 1'b0;
      // hub cycles never reach the user zones
      if (mem_valid && !mem_fwh_cycle && user_en) begin    // [RULE16]
         u0_hit = u0_match;                                // [RULE18]
         u1_hit = dual_user & u1_match;                    // [RULE4]
      end
   end

   // ======================================
   // boot zone decode
   wire lpc_en    = cnf1_r[`XMM_C1_LPC_EN];
   wire fwh_en    = cnf1_r[`XMM_C1_FWH_EN];
   wire dual_boot = cnf2_r[`XMM_C2_DUAL_BOOT];
   wire id_ok     = mem_fwh_id == cnf1_r[`XMM_C1_ID_MSB:`XMM_C1_ID_LSB];        // [RULE8]
   reg  space_ok;
   always @* begin
      if (mem_fwh_cycle) begin
         space_ok = fwh_en & id_ok;       // [RULE9]
      end else begin
         space_ok = lpc_en;               // [RULE9]
      end
   end
   wire b0_match  = (mem_addr | bmask) == 32'hFFFF_FFFF;                        // [RULE7]
   wire b1_match  = ((mem_addr | bmask2) == 32'hFFFF_FFFF) & ~b0_match;          // [RULE6]
   wire b0_hit    = mem_valid & space_ok & b0_match;
   wire b1_hit    = mem_valid & space_ok & dual_boot & b1_match;                // [RULE9] [RULE7]

   // ======================================
   // hit outputs
   wire [3:0] hit_nxt;
   wire [3:0] seen_nxt;
   wire       stat_rd = req & ~wb_we_i & (idx == `XMM_IDX_STATUS);

   // zone 0 wins if a misaligned base makes both match
   assign hit_nxt = {b1_hit, b0_hit, u1_hit & ~u0_hit, u0_hit};

   always @(posedge clock) begin
      if (reset) begin
         user_zone0_hit_r <= 1'b0;
         user_zone1_hit_r <= 1'b0;
         boot_zone0_hit_r <= 1'b0;
         boot_zone1_hit_r <= 1'b0;
         hit_seen_r       <= 4'h0;
      end else if (clock_en) begin
         user_zone0_hit_r <= hit_nxt[0];
         user_zone1_hit_r <= hit_nxt[1];
         boot_zone0_hit_r <= hit_nxt[2];
         boot_zone1_hit_r <= hit_nxt[3];
         hit_seen_r       <= seen_nxt;
      end
   end

   // ======================================
   // sticky hit record
   genvar hi;
   generate
      for (hi = 0; hi < 4; hi = hi + 1) begin : g_seen
         // a status read clears, a new hit in the same cycle wins
         assign seen_nxt[hi] = hit_nxt[hi] | (hit_seen_r[hi] & ~stat_rd);
      end
   endgenerate

endmodule

/* File: testbench/xmm_checker.sv */
`timescale 1ns/1ps
module xmm_checker #(
   parameter ADR_W = 10
) (
   input wire             clock,
   input wire             reset,
   input wire             standby_reset,
   input wire             clock_en,
   input wire             wb_cyc_i,
   input wire             wb_stb_i,
   input wire             wb_we_i,
   input wire [ADR_W-1:0] wb_adr_i,
   input wire [3:0]       wb_sel_i,
   input wire [31:0]      wb_dat_i,
   input wire             wb_ack_o,
   input wire             mem_valid,
   input wire             mem_fwh_cycle,
   input wire [31:0]      mem_addr,
   input wire             user_zone0_hit_r,
   input wire             user_zone1_hit_r,
   input wire             boot_zone0_hit_r,
   input wire             boot_zone1_hit_r,
   input wire             map_lock
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset || standby_reset);
   // ======================================
   // bus request taken, then a write to one index
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && clock_en;
   endsequence
   sequence s_wr(a);
      s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == a);
   endsequence
   a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   a_lock_holds: assert property (s_wr(10'h3E0) ##0 map_lock |=> map_lock)
      else $error("lock cleared by write");
   a_lock_sets: assert property (s_wr(10'h3E0) ##0 wb_dat_i[7] |=> map_lock)
      else $error("lock not set");
   a_unlock_clears: assert property (s_wr(10'h3C0) ##0 wb_dat_i[0] |=> !map_lock)
      else $error("unlock ignored");
   a_user_single: assert property (!(user_zone0_hit_r && user_zone1_hit_r))
      else $error("both user zones hit");
   a_user_plain: assert property (mem_valid && mem_fwh_cycle && clock_en |=> !user_zone0_hit_r && !user_zone1_hit_r)
      else $error("user hit on hub cycle");
   a_boot_top: assert property (clock_en && !(mem_valid && mem_addr[31:24] == 8'hFF)
      |=> !boot_zone0_hit_r && !boot_zone1_hit_r) else $error("boot hit outside top");
   a_idle_quiet: assert property (clock_en && !mem_valid |=> !user_zone0_hit_r && !user_zone1_hit_r)
      else $error("user hit while idle");
endmodule

/* File: testbench/xmm_host.sv */
`timescale 1ns/1ps
module xmm_host (
   input wire        clock,
   output reg        mem_valid,
   output reg        mem_fwh_cycle,
   output reg [3:0]  mem_fwh_id,
   output reg [31:0] mem_addr
);
   initial begin
      mem_valid = 1'b0;
      mem_fwh_cycle = 1'b0;
      mem_fwh_id = 4'h0;
      mem_addr = 32'h0;
   end
   // one address cycle, then lines scrambled
   task issue(input logic f, input logic [3:0] id, input logic [31:0] a);
      @(posedge clock);
      mem_valid <= 1'b1;
      mem_fwh_cycle <= f;
      mem_fwh_id <= id;
      mem_addr <= a;
      @(posedge clock);
      mem_valid <= 1'b0;
      mem_fwh_id <= ~id;
      mem_addr <= ~a;
   endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic        clock = 0, reset = 1, sbr = 1, cyc = 0, we = 0;
   logic [9:0]  adr = 0;
   logic [31:0] dat = 0, rdat, ma;
   logic        ack, u0, u1, b0, b1, lock, mv, mf, v_d = 0;
   logic [3:0]  mid;
   logic [31:0] rd_q[$], hit_q[$];
   int          err_count = 0, checked = 0, cycles = 0;
   always #2.5 clock = ~clock;
   xmm_host i_host(.clock(clock), .mem_valid(mv), .mem_fwh_cycle(mf), .mem_fwh_id(mid), .mem_addr(ma));
   xmm_map_config i_dut(.clock(clock), .reset(reset), .clock_en(1'b1), .standby_reset(sbr),
      .strap_boot_en(1'b0), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_valid(mv),
      .mem_fwh_cycle(mf), .mem_fwh_id(mid), .mem_addr(ma), .user_zone0_hit_r(u0),
      .user_zone1_hit_r(u1), .boot_zone0_hit_r(b0), .boot_zone1_hit_r(b1), .map_lock(lock));
   // ======================================
   // result watcher
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      v_d <= mv;
      if (ack === 1'b1 && !we) check("read data", rdat, rd_q.pop_front());
      if (v_d) check("zone hits", {28'h0, b1, b0, u1, u0}, hit_q.pop_front());
      if (cycles == 5000) begin
         err_count++;
         conclude;
      end
   end
   // ======================================
   // bus and host helpers
   task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clock);
      cyc <= 1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      cyc <= 0;
   endtask
   task rd(input logic [9:0] a, input logic [7:0] e);
      rd_q.push_back({24'h0, e});
      wb(0, a, 8'h0);
   endtask
   task hit(input logic f, input logic [3:0] id, input logic [31:0] a, input logic [3:0] e);
      hit_q.push_back({28'h0, e});
      i_host.issue(f, id, a);
   endtask
   // ======================================
   // main sequence
   initial begin
      int hb, lb, n, s;
      logic [3:0]  id;
      logic [31:0] b, z;
      void'($urandom(8603));
      repeat (5) @(posedge clock);
      reset <= 0;
      sbr <= 0;
      rd(10'h3E0, 8'h00);
      rd(10'h3E4, 8'h00);
      rd(10'h3E8, 8'h00);
      n = $urandom_range(4);
      hb = $urandom_range(8'hEF, 8'h01);
      lb = $urandom_range(255) & ~((1 << n) - 1);
      id = $urandom_range(15);
      wb(1, 10'h3E4, hb);
      wb(1, 10'h3E8, lb);
      wb(1, 10'h3EC, n);
      wb(1, 10'h3DC, {id, 4'hD});
      rd(10'h3E4, hb);
      rd(10'h3E8, lb);
      b = {hb[7:0], lb[7:0], 16'h0};
      z = 32'h1 << (n + 16);
      hit(0, 0, b + $urandom_range(16'hFFFF), 4'h1);
      hit(0, 0, b + z, 4'h0);
      hit(0, 0, b - 1, 4'h0);
      wb(1, 10'h3E0, 8'h10);
      hit(0, 0, b + z + z - 1, 4'h2);
      hit(0, 0, b + z + z, 4'h0);
      wb(1, 10'h3DC, {id, 4'h9});
      hit(0, 0, b, 4'h0);
      for (s = 0; s < 6; s++) begin
         wb(1, 10'h3E0, 8'h08 | s);
         z = 32'h40000 << s;
         hit(0, 0, -z, 4'h4);
         hit(0, 0, -z - 1, 4'h8);
         hit(1, id, -z - z, 4'h8);
         hit(1, ~id, -1, 4'h0);
         hit(0, 0, -z - z - 1, 4'h0);
      end
      wb(1, 10'h3DC, {id, 4'h8});
      hit(1, id, -z - 1, 4'h8);
      wb(1, 10'h3E0, 8'h05);
      hit(1, id, -z - 1, 4'h0);
      wb(1, 10'h3E0, 8'hFD);
      rd(10'h3E0, 8'h9D);
      wb(1, 10'h3E0, 8'h00);
      wb(1, 10'h3E4, 8'h00);
      rd(10'h3E0, 8'h9D);
      rd(10'h3E4, hb);
      wb(1, 10'h3C0, 8'h01);
      rd(10'h3E0, 8'h1D);
      wb(1, 10'h3C0, 8'h02);
      wb(1, 10'h3E0, 8'h80);
      @(posedge clock) reset <= 1;
      @(posedge clock) reset <= 0;
      rd(10'h3E0, 8'h80);
      @(posedge clock) sbr <= 1;
      @(posedge clock) sbr <= 0;
      rd(10'h3E0, 8'h00);
      rd(10'h100, 8'h00);
      repeat (3) @(posedge clock);
      conclude;
   end
endmodule
bind xmm_map_config xmm_checker #(.ADR_W(ADR_W)) i_chk(.clock, .reset, .standby_reset, .clock_en,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .mem_valid, .mem_fwh_cycle,
   .mem_addr, .user_zone0_hit_r, .user_zone1_hit_r, .boot_zone0_hit_r, .boot_zone1_hit_r, .map_lock);
